// ===== rtl/srcc_defines.svh
/*
  Register offsets, field positions, reset values and timing counts
  of the reset and clock control block.
  Assumes inclusion by bare name from the rtl folder.
*/
`ifndef SRCC_DEFINES_SVH
`define SRCC_DEFINES_SVH

// ======================================================================
// Register byte offsets
`define SRCC_OFF_CTRL 12'h000
`define SRCC_OFF_CAUSE 12'h004
`define SRCC_OFF_PWMDIV 12'h008
`define SRCC_OFF_GATE 12'h00C
`define SRCC_OFF_PERIPH_EN 12'h010
`define SRCC_OFF_SLEEP_EN 12'h014
`define SRCC_OFF_STATUS 12'h018
`define SRCC_OFF_PINS 12'h01C
`define SRCC_OFF_SRAM 12'h020
`define SRCC_OFF_IRQ_STAT 12'h024
`define SRCC_OFF_IRQ_MASK 12'h028

// ======================================================================
// Control register fields
`define SRCC_CTRL_SWRESET 0
`define SRCC_CTRL_SLEEP 1

// Reset cause bit positions
`define SRCC_CAUSE_EXT 0
`define SRCC_CAUSE_POR 1
`define SRCC_CAUSE_BOR 2
`define SRCC_CAUSE_WDOG 3
`define SRCC_CAUSE_SW 4
`define SRCC_CAUSE_W 5

// Event status bit positions
`define SRCC_EVT_WAKE 0
`define SRCC_EVT_FAULT 1
`define SRCC_EVT_W 2

// ======================================================================
// Reset values and timing
`define SRCC_PWMDIV_RST 3'h0
`define SRCC_PWMDIV_MAX 3'h6
`define SRCC_PERIPH_READY_CYC 5
`define SRCC_SWRESET_CYC 4
`define SRCC_SRAM_BYTES 32'h00010000
`define SRCC_PIN_MAP_RST 32'h00FFFFFF

`endif

// ===== rtl/srcc_pkg.sv
/*
  Types of the reset and clock control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package srcc_pkg;
  // Processor run state
  typedef enum logic [0:0] {SRCC_RUN, SRCC_SLEEP} srcc_state_e;
  // Divider ratio code, 0 means divide by 1, 6 means 64
  typedef logic [2:0] srcc_div_t;
endpackage

// ===== rtl/srcc_pwm_div.sv
/*
  PWM clock enable divider: one-cycle enable every 2**code cycles.
  Assumes code already limited to the legal range.
*/
`timescale 1ns/100ps
`default_nettype none
`include "srcc_defines.svh"
module srcc_pwm_div
  import srcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sreset,
  input wire srcc_div_t code,
  output logic pwm_en
);
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  srcc_div_t cur_reg;
  srcc_div_t cur_next;
  logic en_next;
  logic [5:0] lim;

  // ======================================================================
  // Counter; a new ratio is taken only at a period boundary or while sreset is high
  always_comb
  begin
    lim = 6'((7'h01 << cur_reg) - 7'h01);
    cnt_next = cnt_reg + 6'h01;
    cur_next = cur_reg;
    en_next = 1'b0;
    // RULE17: switch at boundary
    if (cnt_reg >= lim)
    begin
      cnt_next = 6'h00;
      cur_next = code;
      en_next = 1'b1;
    end
    if (sreset)
    begin
      cnt_next = 6'h00;
      cur_next = code;
      en_next = 1'b0;
    end
  end

  // Registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= 6'h00;
      cur_reg <= `SRCC_PWMDIV_RST;
      pwm_en <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      cur_reg <= cur_next;
      pwm_en <= en_next;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/srcc_sync.sv
/*
  Two-flip-flop synchroniser for a vector of pin levels.
  Assumes inputs asynchronous to pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module srcc_sync #(
  parameter int W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_reg;

  // Two stage capture
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= '0;
      dout <= '0;
    end
    else
    begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/srcc_top.sv
/*
  Reset and clock control: reset cause record, software reset,
  PWM clock divider, sleep gating with wake, capability reads; APB slave.
  Assumes presetn comes from a power-on reset; other reset pins are
  asynchronous pulses and are synchronised here.
*/
`timescale 1ns/100ps
`default_nettype none
`include "srcc_defines.svh"

//Contract
//RULE1: PWM clock enable derives from pclk by 1,2,4,8,16,32 or 64.
//RULE2: Divider setting reads back as one of seven legal codes.
//RULE3: PWM rate follows the system clock proportionally.
//RULE4: Software reset resets processor, peripherals and all registers.
//RULE5: Cause record survives software reset and gains software flag.
//RULE6: Five independent sticky cause flags, several may be set.
//RULE7: Flags clear only by software or external reset.
//RULE8: Software clears any subset of flags in one write.
//RULE9: Software should clear all flags after reading them.
//RULE10: Sleep with gating keeps only sleep-enabled peripherals clocked.
//RULE11: Processor stays halted in sleep until a wake event.
//RULE12: Read-only per-pin presence indication.
//RULE13: Read-only SRAM size in bytes.
//RULE14: Sleep enables kept but ignored when gating is off.
//RULE15: Peripheral usable five cycles after enable; earlier access faults.
//RULE16: Cause flags at chosen bits, cleared by writing one.
//RULE17: Divider change takes effect without a short pulse.
module srcc_top
  import srcc_pkg::*;
#(
  parameter int NPER = 8,
  parameter logic [31:0] SRAM_BYTES = `SRCC_SRAM_BYTES,
  parameter logic [31:0] PIN_MAP = `SRCC_PIN_MAP_RST
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_reset_n,
  input wire logic poweron_reset,
  input wire logic brownout_reset,
  input wire logic watchdog_reset,
  input wire logic [NPER-1:0] periph_wake,
  input wire logic [NPER-1:0] periph_access,
  output logic cpu_reset,
  output logic [NPER-1:0] periph_reset,
  output logic [NPER-1:0] periph_clk_en,
  output logic [NPER-1:0] periph_bus_fault,
  output logic cpu_halt,
  output logic pwm_clk_en,
  output logic irq
);
  localparam int RSTW = $clog2(`SRCC_SWRESET_CYC + 1);
  localparam logic [2:0] READY_CNT = 3'(`SRCC_PERIPH_READY_CYC);

  // ======================================================================
  // Pin synchronisers
  logic [3:0] rst_pins;
  logic [NPER-1:0] wake_s;
  srcc_sync #(.W(4)) u_rsync (
    .pclk(pclk),
    .presetn(presetn),
    .din({~ext_reset_n, poweron_reset, brownout_reset, watchdog_reset}),
    .dout(rst_pins)
  );
  srcc_sync #(.W(NPER)) u_wsync (
    .pclk(pclk),
    .presetn(presetn),
    .din(periph_wake),
    .dout(wake_s)
  );

  // ======================================================================
  // State
  logic [`SRCC_CAUSE_W-1:0] cause_reg, cause_next;
  srcc_div_t div_reg, div_next;
  logic gate_reg, gate_next;
  logic [NPER-1:0] pen_reg, pen_next;
  logic [NPER-1:0] slp_reg, slp_next;
  logic [`SRCC_EVT_W-1:0] ist_reg, ist_next;
  logic [`SRCC_EVT_W-1:0] imsk_reg, imsk_next;
  srcc_state_e st_reg, st_next;
  logic [RSTW-1:0] swr_reg, swr_next;
  logic [31:0] rdata_next;
  logic ready_next;
  logic err_next;
  logic [NPER-1:0] ready_pen;
  logic [NPER-1:0] fault_next;
  logic [NPER-1:0] clk_next;
  logic sreset;
  logic wr;
  logic rd;
  logic wake;
  logic [2:0] wcode;

  assign sreset = (swr_reg != '0);
  assign wr = psel && penable && pwrite && !pready;
  assign rd = psel && penable && !pwrite && !pready;
  assign wcode = pwdata[2:0];

  // ======================================================================
  // Per-peripheral ready counters and clock gating
  genvar gi;
  generate
    for (gi = 0; gi < NPER; gi++)
    begin : g_per
      logic [2:0] cnt_reg;
      logic [2:0] cnt_next;
      // RULE15: five cycle wait
      always_comb
      begin
        if (!pen_reg[gi] || sreset)
          cnt_next = 3'h0;
        else if (cnt_reg < READY_CNT)
          cnt_next = cnt_reg + 3'h1;
        else
          cnt_next = cnt_reg;
      end
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          cnt_reg <= 3'h0;
        else
          cnt_reg <= cnt_next;
      end
      assign ready_pen[gi] = pen_reg[gi] && (cnt_reg >= READY_CNT);
      // RULE15: early access faults
      assign fault_next[gi] = periph_access[gi] && !ready_pen[gi];
      // RULE10: sleep gating
      // RULE14: ignore without gating
      assign clk_next[gi] = pen_reg[gi] &&
        !(st_reg == SRCC_SLEEP && gate_reg && !slp_reg[gi]);
    end
  endgenerate

  // RULE10: wake only from clocked peripherals
  assign wake = |(wake_s & clk_next);

  // ======================================================================
  // Next state of registers and APB answer
  always_comb
  begin
    cause_next = cause_reg;
    div_next = div_reg;
    gate_next = gate_reg;
    pen_next = pen_reg;
    slp_next = slp_reg;
    ist_next = ist_reg;
    imsk_next = imsk_reg;
    st_next = st_reg;
    swr_next = sreset ? swr_reg - RSTW'(1) : swr_reg;
    rdata_next = 32'h00000000;
    ready_next = 1'b0;
    err_next = 1'b0;
    // APB answer one cycle after access phase begins
    if (psel && penable && !pready)
    begin
      ready_next = 1'b1;
      if (rd)
      begin
        unique case (paddr)
          `SRCC_OFF_CTRL: rdata_next = {31'h0, st_reg == SRCC_SLEEP} << `SRCC_CTRL_SLEEP;
          // RULE6: cause read
          `SRCC_OFF_CAUSE: rdata_next = 32'(cause_reg);
          // RULE2: divider readback
          `SRCC_OFF_PWMDIV: rdata_next = 32'(div_reg);
          `SRCC_OFF_GATE: rdata_next = 32'(gate_reg);
          `SRCC_OFF_PERIPH_EN: rdata_next = 32'(pen_reg);
          `SRCC_OFF_SLEEP_EN: rdata_next = 32'(slp_reg);
          `SRCC_OFF_STATUS: rdata_next = 32'(ready_pen);
          // RULE12: pin presence
          `SRCC_OFF_PINS: rdata_next = PIN_MAP;
          // RULE13: SRAM size
          `SRCC_OFF_SRAM: rdata_next = SRAM_BYTES;
          `SRCC_OFF_IRQ_STAT: rdata_next = 32'(ist_reg);
          `SRCC_OFF_IRQ_MASK: rdata_next = 32'(imsk_reg);
          default: err_next = 1'b1;
        endcase
        // Status clears on read
        if (paddr == `SRCC_OFF_IRQ_STAT)
          ist_next = '0;
      end
      else if (wr)
      begin
        unique case (paddr)
          `SRCC_OFF_CTRL:
          begin
            // RULE4: start software reset
            if (pwdata[`SRCC_CTRL_SWRESET])
              swr_next = RSTW'(`SRCC_SWRESET_CYC);
            if (pwdata[`SRCC_CTRL_SLEEP])
              st_next = SRCC_SLEEP;
          end
          // RULE8: write one to clear
          // RULE16: chosen clear scheme
          `SRCC_OFF_CAUSE: cause_next = cause_reg & ~pwdata[`SRCC_CAUSE_W-1:0];
          // RULE1: legal ratios only, others ignored
          `SRCC_OFF_PWMDIV: if (wcode <= `SRCC_PWMDIV_MAX) div_next = wcode;
          `SRCC_OFF_GATE: gate_next = pwdata[0];
          `SRCC_OFF_PERIPH_EN: pen_next = pwdata[NPER-1:0];
          `SRCC_OFF_SLEEP_EN: slp_next = pwdata[NPER-1:0];
          `SRCC_OFF_IRQ_MASK: imsk_next = pwdata[`SRCC_EVT_W-1:0];
          `SRCC_OFF_PINS, `SRCC_OFF_SRAM, `SRCC_OFF_STATUS, `SRCC_OFF_IRQ_STAT: ;
          default: err_next = 1'b1;
        endcase
      end
    end
    // RULE11: leave sleep on wake; software reset also leaves it
    if (st_reg == SRCC_SLEEP && wake)
    begin
      st_next = SRCC_RUN;
      ist_next[`SRCC_EVT_WAKE] = 1'b1;
    end
    if (|fault_next)
      ist_next[`SRCC_EVT_FAULT] = 1'b1;
    // RULE6: sticky cause capture
    if (rst_pins[3]) cause_next[`SRCC_CAUSE_EXT] = 1'b1;
    if (rst_pins[2]) cause_next[`SRCC_CAUSE_POR] = 1'b1;
    if (rst_pins[1]) cause_next[`SRCC_CAUSE_BOR] = 1'b1;
    if (rst_pins[0]) cause_next[`SRCC_CAUSE_WDOG] = 1'b1;
    // RULE7: external reset clears others
    if (rst_pins[3])
    begin
      // Keep only causes seen this cycle
      cause_next = '0;
      cause_next[`SRCC_CAUSE_EXT] = 1'b1;
      cause_next[`SRCC_CAUSE_POR] = rst_pins[2];
      cause_next[`SRCC_CAUSE_BOR] = rst_pins[1];
      cause_next[`SRCC_CAUSE_WDOG] = rst_pins[0];
    end
    // RULE4: defaults on software reset
    if (sreset)
    begin
      div_next = `SRCC_PWMDIV_RST;
      gate_next = 1'b0;
      pen_next = '0;
      slp_next = '0;
      ist_next = '0;
      imsk_next = '0;
      st_next = SRCC_RUN;
      // RULE5: cause survives, gains flag
      cause_next[`SRCC_CAUSE_SW] = 1'b1;
    end
  end

  // ======================================================================
  // Register update
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cause_reg <= `SRCC_CAUSE_W'(1) << `SRCC_CAUSE_POR;
      div_reg <= `SRCC_PWMDIV_RST;
      gate_reg <= 1'b0;
      pen_reg <= '0;
      slp_reg <= '0;
      ist_reg <= '0;
      imsk_reg <= '0;
      st_reg <= SRCC_RUN;
      swr_reg <= '0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      cpu_reset <= 1'b0;
      periph_reset <= '0;
      periph_clk_en <= '0;
      periph_bus_fault <= '0;
      cpu_halt <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      cause_reg <= cause_next;
      div_reg <= div_next;
      gate_reg <= gate_next;
      pen_reg <= pen_next;
      slp_reg <= slp_next;
      ist_reg <= ist_next;
      imsk_reg <= imsk_next;
      st_reg <= st_next;
      swr_reg <= swr_next;
      prdata <= rdata_next;
      pready <= ready_next;
      pslverr <= err_next;
      cpu_reset <= (swr_next != '0);
      periph_reset <= {NPER{swr_next != '0}};
      periph_clk_en <= clk_next;
      periph_bus_fault <= fault_next;
      // RULE11: halt while sleeping
      cpu_halt <= (st_next == SRCC_SLEEP);
      irq <= |(ist_next & imsk_next);
    end
  end

  // ======================================================================
  // PWM clock enable
  // RULE1: divider instance
  // RULE3: runs from pclk
  srcc_pwm_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .sreset(sreset),
    .code(div_reg),
    .pwm_en(pwm_clk_en)
  );
endmodule
`default_nettype wire

// ===== dv/srcc_props.sv
/*
  Port checker of the reset and clock control block.
  Assumes binding into srcc_top, one clock, presetn active low.
*/
`timescale 1ns/100ps
`default_nettype none
module srcc_props #(
  parameter int NPER = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_reset,
  input wire logic [NPER-1:0] periph_reset,
  input wire logic [NPER-1:0] periph_access,
  input wire logic [NPER-1:0] periph_bus_fault,
  input wire logic cpu_halt
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Steps of a bus access and of a software reset
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_swr_write;
    psel && pready && pwrite && paddr == 12'h000 && pwdata[0];
  endsequence
  sequence s_rst_hold;
    cpu_reset [*4] ##1 !cpu_reset;
  endsequence

  // Bus answer timing
  a_ready_wait: assert property (s_wait |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");

  // Software reset pulse
  a_swr_start: assert property (s_swr_write |-> ##[1:2] cpu_reset)
    else $error("software reset not started");
  a_rst_length: assert property ($rose(cpu_reset) |-> s_rst_hold)
    else $error("software reset length wrong");
  a_rst_fanout: assert property (periph_reset == {NPER{cpu_reset}})
    else $error("peripheral reset differs");

  // Faults and sleep entry
  a_fault_cause: assert property (
    |periph_bus_fault |-> (periph_bus_fault & ~$past(periph_access)) == '0)
    else $error("fault without access");
  a_halt_entry: assert property ($rose(cpu_halt) |->
    $past(psel && penable && pwrite && paddr == 12'h000 && pwdata[1]))
    else $error("halt without sleep write");
endmodule

bind srcc_top srcc_props #(.NPER(NPER)) u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .cpu_reset(cpu_reset),
  .periph_reset(periph_reset), .periph_access(periph_access),
  .periph_bus_fault(periph_bus_fault), .cpu_halt(cpu_halt));
`default_nettype wire

// ===== dv/srcc_top_tb.sv
/*
  Self-checking bench of the reset and clock control block.
  Assumes the register map and one-wait-state APB timing of the design.
*/
`timescale 1ns/100ps
`default_nettype none
module srcc_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic ext_reset_n, poweron_reset, brownout_reset, watchdog_reset;
  logic cpu_reset, cpu_halt, pwm_clk_en, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] periph_wake, periph_access, periph_reset, periph_clk_en, periph_bus_fault;
  int mismatches, checked, cyc;

  srcc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_reset_n(ext_reset_n),
    .poweron_reset(poweron_reset), .brownout_reset(brownout_reset),
    .watchdog_reset(watchdog_reset), .periph_wake(periph_wake),
    .periph_access(periph_access), .cpu_reset(cpu_reset),
    .periph_reset(periph_reset), .periph_clk_en(periph_clk_en),
    .periph_bus_fault(periph_bus_fault), .cpu_halt(cpu_halt),
    .pwm_clk_en(pwm_clk_en), .irq(irq));

  // ==========================================================
  // Clock, hang limit and closing report
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      mismatches++;
      results();
    end
  end

  task automatic results();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // Compare and bus tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_pwm();
    logic [31:0] n;
    for (int c = 0; c < 7; c++)
    begin
      wr(12'h008, c);
      rd(12'h008, c);
      repeat (64) @(posedge pclk);
      n = 0;
      repeat (128)
      begin
        @(posedge pclk);
        n = n + pwm_clk_en;
      end
      chk(n, 32'd128 >> c);
    end
    wr(12'h008, 32'h7);
    rd(12'h008, 32'h6);
  endtask

  task automatic t_cause();
    int n;
    rd(12'h004, 32'h02);
    watchdog_reset <= 1'b1;
    brownout_reset <= 1'b1;
    repeat (4) @(posedge pclk);
    watchdog_reset <= 1'b0;
    brownout_reset <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(12'h004, 32'h0E);
    wr(12'h004, 32'h0A);
    rd(12'h004, 32'h04);
    wr(12'h000, 32'h1);
    for (n = 0; n < 20 && cpu_reset !== 1'b1; n++) @(posedge pclk);
    chk(periph_reset, 8'hFF);
    for (n = 0; n < 20 && cpu_reset !== 1'b0; n++) @(posedge pclk);
    rd(12'h004, 32'h14);
    rd(12'h008, 32'h0);
    ext_reset_n <= 1'b0;
    repeat (4) @(posedge pclk);
    ext_reset_n <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(12'h004, 32'h01);
    wr(12'h004, 32'h1F);
    rd(12'h004, 32'h0);
    poweron_reset <= 1'b1;
    repeat (4) @(posedge pclk);
    poweron_reset <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(12'h004, 32'h02);
  endtask

  task automatic t_sleep();
    int n;
    wr(12'h010, 32'h3);
    wr(12'h014, 32'h1);
    wr(12'h00C, 32'h1);
    wr(12'h028, 32'h1);
    wr(12'h000, 32'h2);
    repeat (2) @(posedge pclk);
    chk(cpu_halt, 1);
    chk(periph_clk_en, 8'h01);
    rd(12'h000, 32'h2);
    periph_wake <= 8'h02;
    repeat (8) @(posedge pclk);
    chk(cpu_halt, 1);
    periph_wake <= 8'h01;
    for (n = 0; n < 20 && cpu_halt !== 1'b0; n++) @(posedge pclk);
    periph_wake <= 8'h00;
    repeat (2) @(posedge pclk);
    chk(cpu_halt, 0);
    chk(irq, 1);
    rd(12'h024, 32'h1);
    chk(irq, 0);
    wr(12'h028, 32'h0);
    wr(12'h00C, 32'h0);
    rd(12'h014, 32'h1);
    wr(12'h000, 32'h2);
    repeat (2) @(posedge pclk);
    chk(periph_clk_en, 8'h03);
    periph_wake <= 8'h02;
    for (n = 0; n < 20 && cpu_halt !== 1'b0; n++) @(posedge pclk);
    periph_wake <= 8'h00;
    repeat (2) @(posedge pclk);
    chk(cpu_halt, 0);
    chk(irq, 0);
    rd(12'h024, 32'h1);
  endtask

  task automatic t_fault();
    logic [31:0] q;
    logic e;
    wr(12'h028, 32'h2);
    rd(12'h028, 32'h2);
    wr(12'h010, 32'h7);
    periph_access <= 8'h04;
    @(posedge pclk);
    periph_access <= 8'h00;
    @(posedge pclk);
    chk(periph_bus_fault, 8'h04);
    repeat (8) @(posedge pclk);
    periph_access <= 8'h04;
    @(posedge pclk);
    periph_access <= 8'h00;
    @(posedge pclk);
    chk(periph_bus_fault, 8'h00);
    rd(12'h018, 32'h07);
    chk(irq, 1);
    rd(12'h024, 32'h2);
    chk(irq, 0);
    apb(1'b0, 12'h100, 32'h0, q, e);
    chk(e, 1);
  endtask

  // Reset, then the scenarios in turn
  initial
  begin
    {presetn, psel, penable, pwrite, poweron_reset, brownout_reset, watchdog_reset} = '0;
    ext_reset_n = 1'b1;
    paddr = '0;
    pwdata = '0;
    periph_wake = '0;
    periph_access = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h020, 32'h00010000);
    rd(12'h01C, 32'h00FFFFFF);
    t_pwm();
    t_cause();
    t_sleep();
    t_fault();
    results();
  end
endmodule
`default_nettype wire
